// ---- pcxs_cap_regs.sv ----
// extended-capability status register group on the configuration port
`timescale 1ns/1ns
module pcxs_cap_regs import pcxs_pkg::*; (
	// clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,

	// configuration transaction, one cycle per request
	input wire logic cfg_req_i,
	input wire logic cfg_we_i,
	input wire logic cfg_type0_i,
	input wire logic cfg_idsel_i,
	input wire logic [5:0] cfg_dw_addr_i,
	input wire logic [2:0] cfg_func_i,
	input wire logic [3:0] cfg_be_i,

	// configuration answer
	output logic cfg_ack_o,
	output logic cfg_hit_o,
	output logic [31:0] cfg_rdata_o,

	// secondary bus identity
	input wire logic [7:0] sec_bus_num_i,

	// secondary-side split events, from core logic
	input wire logic cpl_unexp_i,
	input wire logic [7:0] cpl_bus_i,
	input wire logic [4:0] cpl_dev_i,
	input wire logic [2:0] cpl_func_i,
	input wire logic cpl_discard_i,
	input wire logic cpl_overrun_i,
	input wire logic req_delayed_i,

	// secondary interface capability pins
	input wire logic sec_cap133_pin_i,
	input wire logic [2:0] sec_clk_mode_pin_i,

	// captured identity for the rest of the bridge
	output logic [2:0] func_num_o
);

	// ****************************************
	// decode helpers
	// ****************************************

	// dword index belongs to this group
	function automatic logic in_group(input logic [5:0] idx);
		in_group = (idx == PCXS_CAP_IDX) || (idx == PCXS_BRG_IDX);
	endfunction

	// byte enables widened to a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// only the defined codes are passed on; reserved codes read as conventional mode
	function automatic logic [2:0] clk_code(input logic [2:0] raw);
		case (raw)
			PCXS_CLK_CONV: clk_code = PCXS_CLK_CONV;
			PCXS_CLK_66: clk_code = PCXS_CLK_66;
			PCXS_CLK_133: clk_code = PCXS_CLK_133;
			default: clk_code = PCXS_CLK_CONV;
		endcase
	endfunction

	// ****************************************
	// internal signals
	// ****************************************
	logic cap133_sync;
	logic [2:0] clk_mode_sync;
	logic cap133;
	logic [2:0] clk_mode;
	logic [2:0] func_num;
	logic own_write;
	logic [31:0] cap_dword;
	logic [31:0] brg_dword;
	logic [31:0] next_rdata;
	logic next_hit;

	pcxs_flags_if flags_bus();

	// ****************************************
	// pin synchronisers
	// ****************************************
	pcxs_pin_sync #(
		.WIDTH(1),
		.RST_VAL(1'h0)
	) u_sync_cap133 (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.pin_i(sec_cap133_pin_i),
		.level_o(cap133_sync)
	);

	pcxs_pin_sync #(
		.WIDTH(3),
		.RST_VAL(PCXS_CLK_MODE_RST)
	) u_sync_clk (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.pin_i(sec_clk_mode_pin_i),
		.level_o(clk_mode_sync)
	);

	// ****************************************
	// split event tracker
	// ****************************************
	pcxs_split_track u_track (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.sec_bus_num_i(sec_bus_num_i),
		.cpl_unexp_i(cpl_unexp_i),
		.cpl_bus_i(cpl_bus_i),
		.cpl_dev_i(cpl_dev_i),
		.cpl_func_i(cpl_func_i),
		.cpl_discard_i(cpl_discard_i),
		.cpl_overrun_i(cpl_overrun_i),
		.req_delayed_i(req_delayed_i),
		.flags(flags_bus.tracker)
	);

	// ****************************************
	// secondary capability state
	// ****************************************

	// capability pin level is followed on every clock after reset release, never under the async reset
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cap133 <= 1'h0;
		end else begin
			cap133 <= cap133_sync;
		end
	end

	// reserved codes are folded away so software never sees them
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			clk_mode <= PCXS_CLK_MODE_RST;
		end else begin
			clk_mode <= clk_code(clk_mode_sync);
		end
	end

	// ****************************************
	// function number capture
	// ****************************************

	// a type-0 write that selects the bridge updates the number, whatever register it targets
	assign own_write = cfg_req_i && cfg_we_i && cfg_type0_i && cfg_idsel_i;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			func_num <= PCXS_FUNC_RST;
		end else if (own_write) begin
			func_num <= cfg_func_i;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			func_num_o <= PCXS_FUNC_RST;
		end else begin
			func_num_o <= func_num;
		end
	end

	// ****************************************
	// register images
	// ****************************************
	always_comb begin
		cap_dword = 32'h0000_0000;
		cap_dword[PCXS_ID_LSB +: 8] = PCXS_CAP_ID;
		cap_dword[PCXS_PTR_LSB +: 8] = PCXS_NEXT_PTR;
		cap_dword[PCXS_WIDE_BIT] = PCXS_WIDE_SEC;
		cap_dword[PCXS_C133_BIT] = cap133;
		cap_dword[PCXS_DISC_BIT] = flags_bus.discarded;
		cap_dword[PCXS_UNEXP_BIT] = flags_bus.unexpected;
		cap_dword[PCXS_OVRN_BIT] = flags_bus.overrun;
		cap_dword[PCXS_DLY_BIT] = flags_bus.delayed;
		cap_dword[PCXS_CLK_LSB +: 3] = clk_mode;
	end

	always_comb begin
		brg_dword = 32'h0000_0000;
		brg_dword[PCXS_FUNC_LSB +: 3] = func_num;
	end

	// ****************************************
	// read mux
	// ****************************************

	// writes are answered like reads and store nothing here but the function number; data returned on reads only
	always_comb begin
		next_hit = in_group(cfg_dw_addr_i);
		next_rdata = 32'h0000_0000;
		if (cfg_req_i && !cfg_we_i) begin
			case (cfg_dw_addr_i)
				PCXS_CAP_IDX: next_rdata = cap_dword & lane_mask(cfg_be_i);
				PCXS_BRG_IDX: next_rdata = brg_dword & lane_mask(cfg_be_i);
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// answer registers
	// ****************************************
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_ack_o <= 1'h0;
		end else begin
			cfg_ack_o <= cfg_req_i;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_hit_o <= 1'h0;
		end else begin
			cfg_hit_o <= cfg_req_i && next_hit;
		end
	end

	// data stays zero between answers so a stale read is never mistaken for a new one
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_rdata_o <= 32'h0000_0000;
		end else begin
			cfg_rdata_o <= next_rdata;
		end
	end

endmodule

// ---- pcxs_pkg.sv ----
// constants for the extended-capability status register group
package pcxs_pkg;

	// ****************************************
	// register offsets (byte address, dword index)
	// ****************************************
	localparam logic [7:0] PCXS_CAP_OFS = 8'h80;
	localparam logic [7:0] PCXS_BRG_OFS = 8'h84;
	localparam logic [5:0] PCXS_CAP_IDX = 6'h20;
	localparam logic [5:0] PCXS_BRG_IDX = 6'h21;

	// ****************************************
	// fixed values and reset values
	// ****************************************
	localparam logic [7:0] PCXS_CAP_ID = 8'h07;
	localparam logic [7:0] PCXS_NEXT_PTR = 8'h90;
	localparam logic PCXS_WIDE_SEC = 1'h0;
	localparam logic [2:0] PCXS_CLK_MODE_RST = 3'h0;
	localparam logic [2:0] PCXS_FUNC_RST = 3'h0;
	localparam logic [4:0] PCXS_OWN_DEV = 5'h00;
	localparam logic [2:0] PCXS_OWN_FUNC = 3'h0;

	// ****************************************
	// field positions in the dword at 80h
	// ****************************************
	localparam int PCXS_ID_LSB = 0;
	localparam int PCXS_PTR_LSB = 8;
	localparam int PCXS_WIDE_BIT = 16;
	localparam int PCXS_C133_BIT = 17;
	localparam int PCXS_DISC_BIT = 18;
	localparam int PCXS_UNEXP_BIT = 19;
	localparam int PCXS_OVRN_BIT = 20;
	localparam int PCXS_DLY_BIT = 21;
	localparam int PCXS_CLK_LSB = 22;

	// ****************************************
	// secondary clock mode codes
	// ****************************************
	localparam logic [2:0] PCXS_CLK_CONV = 3'h0;
	localparam logic [2:0] PCXS_CLK_66 = 3'h1;
	localparam logic [2:0] PCXS_CLK_133 = 3'h2;

	// field position in the dword at 84h
	localparam int PCXS_FUNC_LSB = 0;

	// synchroniser depth for pin inputs
	localparam int PCXS_SYNC_STAGES = 3;

endpackage

// ---- pcxs_flags_if.sv ----
// sticky split-event flags passed from the event tracker to the register group
`timescale 1ns/1ns
interface pcxs_flags_if;
	logic discarded;
	logic unexpected;
	logic overrun;
	logic delayed;

	modport tracker (
		output discarded,
		output unexpected,
		output overrun,
		output delayed
	);

	modport regs (
		input discarded,
		input unexpected,
		input overrun,
		input delayed
	);
endinterface

// ---- pcxs_pin_sync.sv ----
// three-stage synchroniser for pin levels, change taken when stages two and three agree
`timescale 1ns/1ns
module pcxs_pin_sync import pcxs_pkg::*; #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// pin side
	input wire logic [WIDTH-1:0] pin_i,
	// core side
	output logic [WIDTH-1:0] level_o
);

	// ****************************************
	// per-bit stages
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic [PCXS_SYNC_STAGES-1:0] stage;

			// stage 0 is only read by stage 1
			always_ff @(posedge clock_i or negedge nrst_i) begin
				if (!nrst_i) begin
					stage <= '0;
				end else begin
					stage <= {stage[PCXS_SYNC_STAGES-2:0], pin_i[g]};
				end
			end

			// a single disagreeing sample is not taken as a change
			always_ff @(posedge clock_i or negedge nrst_i) begin
				if (!nrst_i) begin
					level_o[g] <= RST_VAL[g];
				end else if (stage[1] == stage[2]) begin
					level_o[g] <= stage[2];
				end
			end
		end
	endgenerate

endmodule

// ---- pcxs_split_track.sv ----
// secondary-side split event tracker with sticky flags
`timescale 1ns/1ns
module pcxs_split_track import pcxs_pkg::*; (
	// clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// own identity on the secondary side
	input wire logic [7:0] sec_bus_num_i,
	// split completion seen on the secondary side
	input wire logic cpl_unexp_i,
	input wire logic [7:0] cpl_bus_i,
	input wire logic [4:0] cpl_dev_i,
	input wire logic [2:0] cpl_func_i,
	// other split events
	input wire logic cpl_discard_i,
	input wire logic cpl_overrun_i,
	input wire logic req_delayed_i,
	// flags out
	pcxs_flags_if.tracker flags
);

	// requester id that names the bridge itself on the secondary side
	function automatic logic own_id(input logic [7:0] bus, input logic [4:0] dev, input logic [2:0] fn,
		input logic [7:0] own_bus);
		own_id = (bus == own_bus) && (dev == PCXS_OWN_DEV) && (fn == PCXS_OWN_FUNC);
	endfunction

	// ****************************************
	// sticky flags, only reset clears them
	// ****************************************
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flags.unexpected <= 1'h0;
		end else if (cpl_unexp_i && own_id(cpl_bus_i, cpl_dev_i, cpl_func_i, sec_bus_num_i)) begin
			flags.unexpected <= 1'h1;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flags.delayed <= 1'h0;
		end else if (req_delayed_i) begin
			flags.delayed <= 1'h1;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flags.discarded <= 1'h0;
			flags.overrun <= 1'h0;
		end else begin
			flags.discarded <= flags.discarded | cpl_discard_i;
			flags.overrun <= flags.overrun | cpl_overrun_i;
		end
	end

endmodule

// ---- pcxs_cap_regs_properties.sv ----
// assertions on the ports of the capability status register group
`timescale 1ns/1ns
module pcxs_cap_regs_chk (
	// clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// configuration port
	input wire logic cfg_req_i,
	input wire logic cfg_we_i,
	input wire logic cfg_type0_i,
	input wire logic cfg_idsel_i,
	input wire logic [5:0] cfg_dw_addr_i,
	input wire logic [2:0] cfg_func_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic cfg_ack_o,
	input wire logic cfg_hit_o,
	input wire logic [31:0] cfg_rdata_o,
	input wire logic [2:0] func_num_o,
	// split events
	input wire logic [7:0] sec_bus_num_i,
	input wire logic cpl_unexp_i,
	input wire logic [7:0] cpl_bus_i,
	input wire logic [4:0] cpl_dev_i,
	input wire logic [2:0] cpl_func_i,
	input wire logic cpl_discard_i,
	input wire logic cpl_overrun_i,
	input wire logic req_delayed_i
);
	logic p_rd;
	logic [5:0] p_adr;
	logic [3:0] p_be;
	logic [3:0] seen;
	logic [3:0] p_seen;
	logic rd80;
	// ****
	// last request, and flags as the read saw them
	// ****
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			p_rd <= 1'b0;
			p_adr <= 6'h00;
			p_be <= 4'h0;
			seen <= 4'h0;
			p_seen <= 4'h0;
		end else begin
			p_rd <= cfg_req_i && !cfg_we_i;
			p_adr <= cfg_dw_addr_i;
			p_be <= cfg_be_i;
			p_seen <= seen;
			seen <= seen | {req_delayed_i, cpl_overrun_i,
				cpl_unexp_i && cpl_bus_i == sec_bus_num_i && cpl_dev_i == 5'h00 && cpl_func_i == 3'h0, cpl_discard_i};
		end
	end
	assign rd80 = cfg_ack_o && p_rd && p_adr == 6'h20;
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);
	a_ack_timing: assert property (cfg_req_i |=> cfg_ack_o) else $error("late answer");
	a_hit_decode: assert property (cfg_ack_o |-> cfg_hit_o == (p_adr[5:1] == 5'h10)) else $error("bad hit");
	a_cap_id: assert property (rd80 && p_be[0] |-> cfg_rdata_o[7:0] == 8'h07) else $error("bad id");
	a_next_ptr: assert property (rd80 && p_be[1] |-> cfg_rdata_o[15:8] == 8'h90) else $error("bad link");
	a_wide_zero: assert property (rd80 && p_be[2] |-> !cfg_rdata_o[16]) else $error("bad width");
	a_split_flags: assert property (rd80 && p_be[2] |-> cfg_rdata_o[21:18] == p_seen) else $error("bad flags");
	a_func_capture: assert property (cfg_req_i && cfg_we_i && cfg_type0_i && cfg_idsel_i
		|-> ##2 func_num_o == $past(cfg_func_i, 2)) else $error("bad capture");
	a_func_readback: assert property (cfg_ack_o && p_rd && p_adr == 6'h21 && p_be[0]
		|-> cfg_rdata_o[2:0] == func_num_o) else $error("bad function");
endmodule
bind pcxs_cap_regs pcxs_cap_regs_chk chk (.*);

// ---- pcxs_host_model.sv ----
// host model issuing configuration requests
`timescale 1ns/1ns
module pcxs_host_model (
	// clock and answer
	input wire logic clock_i,
	input wire logic ack_i,
	input wire logic hit_i,
	input wire logic [31:0] rdata_i,
	// request
	output logic req_o,
	output logic we_o,
	output logic type0_o,
	output logic idsel_o,
	output logic [5:0] addr_o,
	output logic [2:0] func_o,
	output logic [3:0] be_o
);
	initial begin
		{req_o, we_o, type0_o, idsel_o, addr_o, func_o, be_o} = 17'h00000;
	end
	// idle fields are inverted so a stale value is never mistaken for a request
	task automatic xfer(input logic w, t, s, input logic [5:0] a, input logic [2:0] f, input logic [3:0] b,
		output logic [31:0] d, output logic [1:0] h);
		@(negedge clock_i);
		{req_o, we_o, type0_o, idsel_o, addr_o, func_o, be_o} = {1'b1, w, t, s, a, f, b};
		@(negedge clock_i);
		d = rdata_i;
		h = {ack_i, hit_i};
		{req_o, we_o, type0_o, idsel_o, addr_o, func_o, be_o} = {1'b0, ~w, ~t, ~s, ~a, ~f, ~b};
	endtask
endmodule

// ---- tb_pcxs_cap_regs.sv ----
// self-checking bench for the capability status register group
`timescale 1ns/1ns
module tb_pcxs_cap_regs;
	logic clock_i, nrst_i, req, we, t0, ids, ack, hit, c133, unx, dsc, ovr, dly, t, s;
	logic [5:0] adr;
	logic [2:0] fn, mode, cfn, fnum, efn, f;
	logic [3:0] be, fl;
	logic [7:0] sbus, cbus;
	logic [4:0] cdev;
	logic [31:0] rd, d;
	logic [1:0] h;
	int n_errors = 0;
	int checks = 0;
	pcxs_host_model host (.clock_i(clock_i), .ack_i(ack), .hit_i(hit), .rdata_i(rd), .req_o(req), .we_o(we),
		.type0_o(t0), .idsel_o(ids), .addr_o(adr), .func_o(fn), .be_o(be));
	pcxs_cap_regs dut (.clock_i(clock_i), .nrst_i(nrst_i), .cfg_req_i(req), .cfg_we_i(we), .cfg_type0_i(t0),
		.cfg_idsel_i(ids), .cfg_dw_addr_i(adr), .cfg_func_i(fn), .cfg_be_i(be), .cfg_ack_o(ack), .cfg_hit_o(hit),
		.cfg_rdata_o(rd), .sec_bus_num_i(sbus), .cpl_unexp_i(unx), .cpl_bus_i(cbus), .cpl_dev_i(cdev),
		.cpl_func_i(cfn), .cpl_discard_i(dsc), .cpl_overrun_i(ovr), .req_delayed_i(dly),
		.sec_cap133_pin_i(c133), .sec_clk_mode_pin_i(mode), .func_num_o(fnum));
	// ****
	// expectations and helpers
	// ****
	function automatic logic [31:0] img(logic [3:0] b);
		logic [31:0] v;
		v = {7'h00, (mode > 3'h2) ? 3'h0 : mode, fl, c133, 1'b0, 8'h90, 8'h07};
		for (int i = 0; i < 4; i++) begin
			if (!b[i]) v[8*i+:8] = 8'h00;
		end
		return v;
	endfunction
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask
	task automatic close_out();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic rd80(logic [3:0] b);
		host.xfer(1'b0, 1'b1, 1'b1, 6'h20, 3'h0, b, d, h);
		chk("answer", 32'h3, {30'h0, h});
		chk("status", img(b), d);
	endtask
	task automatic rd84();
		host.xfer(1'b0, 1'b1, 1'b1, 6'h21, 3'h0, 4'hF, d, h);
		chk("function", {29'h0, efn}, d);
		chk("function out", {29'h0, efn}, {29'h0, fnum});
	endtask
	task automatic ev(int k);
		@(negedge clock_i);
		{dsc, ovr, dly, unx} = {k == 0, k == 1, k == 2, k > 2};
		cbus = (k == 4) ? sbus + 8'h01 : sbus;
		cdev = (k == 5) ? 5'($urandom_range(1, 31)) : 5'h00;
		cfn = (k == 6) ? 3'($urandom_range(1, 7)) : 3'h0;
		fl = fl | {dly, ovr, k == 3, dsc};
		@(negedge clock_i);
		{unx, dsc, ovr, dly} = 4'h0;
		{cbus, cdev, cfn} = {~sbus, 8'hFF};
	endtask
	task automatic do_reset();
		@(negedge clock_i);
		nrst_i = 1'b0;
		{fl, efn} = 7'h00;
		repeat (2) @(negedge clock_i);
		nrst_i = 1'b1;
		repeat (6) @(negedge clock_i);
	endtask
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	initial begin
		#100000;
		n_errors++;
		close_out();
	end
	initial begin
		nrst_i = 1'b0;
		{unx, dsc, ovr, dly, c133, mode} = 8'h00;
		void'($urandom(8071));
		sbus = 8'($urandom);
		{cbus, cdev, cfn} = {~sbus, 8'hFF};
		do_reset();
		rd80(4'hF);
		rd84();
		host.xfer(1'b1, 1'b0, 1'b0, 6'h20, 3'h7, 4'hF, d, h);
		chk("write data", 32'h0, d);
		chk("write answer", 32'h3, {30'h0, h});
		rd80(4'hF);
		host.xfer(1'b0, 1'b1, 1'b1, 6'($urandom_range(0, 31)), 3'h0, 4'hF, d, h);
		chk("unmapped data", 32'h0, d);
		chk("unmapped answer", 32'h2, {30'h0, h});
		for (int m = 0; m < 8; m++) begin
			@(negedge clock_i);
			mode = m[2:0];
			c133 = 1'($urandom);
			repeat (6) @(negedge clock_i);
			rd80(4'hF);
		end
		for (int i = 0; i < 40; i++) begin
			ev($urandom_range(0, 6));
			rd80(4'($urandom));
		end
		for (int i = 0; i < 20; i++) begin
			{t, s, f} = 5'($urandom);
			host.xfer(1'b1, t, s, 6'($urandom), f, 4'($urandom), d, h);
			if (t && s) efn = f;
			rd84();
		end
		do_reset();
		rd80(4'hF);
		rd84();
		close_out();
	end
endmodule
